// ### design/adc_group_scan_sequencer.sv
/*
 * group scan sequencer of a 10-bit successive approximation converter:
 * register file, trigger handling, group priority, halting, result storage
 * and checks. assumes an analog front end driven by afe and a comparator
 * whose output arrives asynchronously on comp_in.
 */
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps

// Function
// - 16 channels, 10-bit successive approximation results
// - three groups, one scan list register each
// - scan lists may change while running
// - group zero mode bit selects continuous rescan
// - groups one and two always one-shot
// - each channel converted 1 to 4 times, once only for group zero in continuous mode
// - scan ascending from channel zero
// - priority group two, one, then zero
// - higher trigger or halt input halts conversion
// - halt bit 0: abort, later reconvert channel
// - halt bit 1: finish channel, resume next
// - three-bit group active status field
// - pulse event on every conversion completed while enabled
// - store per-channel, last, group-last results
// - group interrupt per selected channel or end
// - enabled channels checked against lower/upper limits
// - flag overwrite of unread result
// - optional discharge before each sampling
// - triggers accepted after stabilisation time only
// - start by software bit or hardware input
// - converter clock rate from frequency select field
// - ignore triggers for empty scan list
// - start at next converter tick, set active
module adc_group_scan_sequencer
    import adc_seq_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  arst_n,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [31:0]           reg_rdata,
    input  wire logic [2:0]            hw_start_input,
    input  wire logic                  halt_mode_trigger,
    input  wire logic                  comp_in,
    output adc_seq_pkg::afe_ctrl_t     afe,
    output logic                       per_conversion_event,
    output logic      [2:0]            group_end_irq
);
    import adc_seq_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // reset release and input synchronisers
    logic       rst_q1, rst_n;
    logic [2:0] hw_s1, hw_s2, hw_s3;
    logic       halt_s1, halt_s2, comp_s1, comp_s2;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hw_s1   <= 3'h0;
            hw_s2   <= 3'h0;
            hw_s3   <= 3'h0;
            halt_s1 <= 1'b0;
            halt_s2 <= 1'b0;
            comp_s1 <= 1'b0;
            comp_s2 <= 1'b0;
        end else begin
            hw_s1   <= hw_start_input;
            hw_s2   <= hw_s1;
            hw_s3   <= hw_s2;
            halt_s1 <= halt_mode_trigger;
            halt_s2 <= halt_s1;
            comp_s1 <= comp_in;
            comp_s2 <= comp_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state
    logic        enable, power, mode0, trig_mode, disch_en;
    logic [1:0]  rep_cfg [NUM_GRP];
    logic [2:0]  halt_meth;
    logic [3:0]  freq;
    logic [15:0] limit_en, stab_val, range_st, ovw_st, unread;
    logic [9:0]  lower, upper, last_res, approximation_register;
    logic [15:0] scan [NUM_GRP];
    logic [15:0] ioc [NUM_GRP];
    logic [9:0]  grp_res [NUM_GRP];
    logic [9:0]  ch_res [NUM_CH];
    logic [3:0]  last_ch, cur_ch, phase, bit_idx;
    logic [2:0]  active;
    logic [3:0]  ch_pos [NUM_GRP];
    logic [1:0]  rep_cnt [NUM_GRP];
    logic [1:0]  cur_grp;
    logic [5:0]  div_cnt;
    logic [15:0] stab_cnt;
    logic        stab_done, en_q;
    conv_state_t state;

    logic        next_enable, next_power, next_mode0, next_trig_mode, next_disch_en;
    logic [1:0]  next_rep_cfg [NUM_GRP];
    logic [2:0]  next_halt_meth;
    logic [3:0]  next_freq;
    logic [15:0] next_limit_en, next_stab_val, next_range_st, next_ovw_st, next_unread;
    logic [9:0]  next_lower, next_upper, next_last_res, next_sar;
    logic [15:0] next_scan [NUM_GRP];
    logic [15:0] next_ioc [NUM_GRP];
    logic [9:0]  next_grp_res [NUM_GRP];
    logic [9:0]  next_ch_res [NUM_CH];
    logic [3:0]  next_last_ch, next_cur_ch, next_phase, next_bit_idx;
    logic [2:0]  next_active;
    logic [3:0]  next_ch_pos [NUM_GRP];
    logic [1:0]  next_rep_cnt [NUM_GRP];
    logic [1:0]  next_cur_grp;
    logic [5:0]  next_div_cnt;
    logic [15:0] next_stab_cnt;
    logic        next_stab_done;
    conv_state_t next_state;
    logic [31:0] next_rdata;
    afe_ctrl_t   next_afe;
    logic        next_event;
    logic [2:0]  next_irq;

    // lowest channel of list at or above start; bit 4 marks a hit
    function automatic logic [4:0] find_chan(input logic [15:0] list, input logic [4:0] start);
        logic [4:0] res;
        res = 5'h00;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (5'(i) >= start && list[i]) begin
                res = {1'b1, 4'(i)};
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic       tick, ready, preempt, grp_end, sel_any;
        logic [1:0] sel_grp;
        logic [4:0] hit;
        logic [9:0] trial;
        logic [2:0] start_req;
        tick = 1'b0; ready = 1'b0; preempt = 1'b0; sel_any = 1'b0; sel_grp = 2'd0;
        next_enable = enable; next_power = power; next_mode0 = mode0;
        next_trig_mode = trig_mode; next_disch_en = disch_en;
        next_halt_meth = halt_meth; next_freq = freq; next_limit_en = limit_en;
        next_stab_val = stab_val; next_range_st = range_st; next_ovw_st = ovw_st;
        next_unread = unread; next_lower = lower; next_upper = upper;
        next_last_res = last_res; next_sar = approximation_register; next_last_ch = last_ch;
        next_cur_ch = cur_ch; next_phase = phase; next_bit_idx = bit_idx;
        next_active = active; next_cur_grp = cur_grp; next_state = state;
        next_stab_cnt = stab_cnt; next_stab_done = stab_done;
        next_rep_cfg = rep_cfg; next_scan = scan; next_ioc = ioc;
        next_grp_res = grp_res; next_ch_res = ch_res; next_ch_pos = ch_pos;
        next_rep_cnt = rep_cnt;
        next_rdata = 32'h0000_0000;
        next_event = 1'b0;
        next_irq = 3'h0;
        start_req = 3'h0;
        grp_end = 1'b0;
        hit = 5'h00;
        trial = 10'h000;

        // register writes; status clears come first so a same-cycle set wins
        if (reg_wr) begin
            case (reg_addr)
                OFS_CTL0: begin
                    next_enable = reg_wdata[CTL0_ENABLE];
                    for (int g = 0; g < NUM_GRP; g++) begin
                        next_rep_cfg[g] = reg_wdata[CTL0_REPEAT + 2 * g +: 2];
                    end
                end
                OFS_CTL1: begin
                    next_power     = reg_wdata[CTL1_POWER];
                    next_mode0     = reg_wdata[CTL1_MODE0];
                    next_trig_mode = reg_wdata[CTL1_TRIGMODE];
                    next_disch_en  = reg_wdata[CTL1_DISCH];
                    next_halt_meth = reg_wdata[CTL1_HALT +: 3];
                    next_freq      = reg_wdata[CTL1_FREQ +: 4];
                end
                OFS_CTL2:     next_limit_en = reg_wdata[15:0];
                OFS_STAB:     next_stab_val = reg_wdata[15:0];
                OFS_LOWER:    next_lower = reg_wdata[9:0];
                OFS_UPPER:    next_upper = reg_wdata[9:0];
                OFS_TRIG:     start_req = trig_mode ? 3'h0 : reg_wdata[2:0];
                OFS_RANGE_ST: next_range_st = range_st & ~reg_wdata[15:0];
                OFS_OVW_ST:   next_ovw_st = ovw_st & ~reg_wdata[15:0];
                default: begin
                    for (int g = 0; g < NUM_GRP; g++) begin
                        if (reg_addr == OFS_SCAN + 8'(4 * g)) next_scan[g] = reg_wdata[15:0];
                        if (reg_addr == OFS_IOC + 8'(4 * g)) next_ioc[g] = reg_wdata[15:0];
                    end
                end
            endcase
        end

        // register reads, answered in the following cycle
        if (reg_rd) begin
            case (reg_addr)
                OFS_CTL0: begin
                    next_rdata[CTL0_ENABLE] = enable;
                    for (int g = 0; g < NUM_GRP; g++) begin
                        next_rdata[CTL0_REPEAT + 2 * g +: 2] = rep_cfg[g];
                    end
                end
                OFS_CTL1: begin
                    next_rdata[CTL1_POWER] = power;
                    next_rdata[CTL1_MODE0] = mode0;
                    next_rdata[CTL1_TRIGMODE] = trig_mode;
                    next_rdata[CTL1_DISCH] = disch_en;
                    next_rdata[CTL1_HALT +: 3] = halt_meth;
                    next_rdata[CTL1_FREQ +: 4] = freq;
                end
                OFS_CTL2:      next_rdata[15:0] = limit_en;
                OFS_STAB:      next_rdata[15:0] = stab_val;
                OFS_LOWER:     next_rdata[9:0] = lower;
                OFS_UPPER:     next_rdata[9:0] = upper;
                OFS_RANGE_ST:  next_rdata[15:0] = range_st;
                OFS_OVW_ST:    next_rdata[15:0] = ovw_st;
                OFS_ACTIVE_ST: next_rdata = {23'h0, stab_done, 5'h0, active};
                OFS_LAST_RES:  next_rdata = {12'h0, last_ch, 6'h0, last_res};
                default: begin
                    for (int g = 0; g < NUM_GRP; g++) begin
                        if (reg_addr == OFS_SCAN + 8'(4 * g)) next_rdata[15:0] = scan[g];
                        if (reg_addr == OFS_IOC + 8'(4 * g)) next_rdata[15:0] = ioc[g];
                        if (reg_addr == OFS_GRP_RES + 8'(4 * g)) next_rdata[9:0] = grp_res[g];
                    end
                    if (reg_addr[7:6] == OFS_CH_RES[7:6] && reg_addr[1:0] == 2'h0) begin
                        next_rdata[9:0] = ch_res[reg_addr[5:2]];
                        next_unread[reg_addr[5:2]] = 1'b0;
                    end
                end
            endcase
        end

        // converter clock tick from the frequency select field
        tick = (div_cnt == 6'h00);
        next_div_cnt = tick ? 6'(({2'h0, freq} + 6'h01) * DIV_SCALE - 6'h01) : div_cnt - 6'h01;

        // stabilisation counter restarts on every enable with power on
        if (!(enable && power)) begin
            next_stab_cnt  = 16'h0000;
            next_stab_done = 1'b0;
        end else if (!en_q) begin
            next_stab_cnt  = 16'h0000;
            next_stab_done = 1'b0;
        end else if (tick && !stab_done) begin
            next_stab_cnt  = stab_cnt + 16'h0001;
            next_stab_done = (stab_cnt >= stab_val);
        end
        ready = enable && power && stab_done;

        // trigger acceptance
        if (trig_mode) start_req = hw_s2 & ~hw_s3;
        for (int g = 0; g < NUM_GRP; g++) begin
            if (ready && start_req[g] && scan[g] != 16'h0000 && !active[g]) begin
                next_active[g] = 1'b1;
                next_ch_pos[g] = 4'h0;
                next_rep_cnt[g] = 2'h0;
            end
        end

        // highest pending group
        sel_any = |active;
        sel_grp = active[2] ? 2'd2 : (active[1] ? 2'd1 : 2'd0);
        preempt = halt_s2 || (sel_any && sel_grp > cur_grp);

        case (state)
            ST_IDLE: begin
                if (tick && sel_any && !halt_s2) begin
                    hit = find_chan(scan[sel_grp], {1'b0, ch_pos[sel_grp]});
                    next_cur_grp = sel_grp;
                    next_phase = 4'h0;
                    if (hit[4]) begin
                        next_cur_ch = hit[3:0];
                        next_state = disch_en ? ST_DISCH : ST_SAMPLE;
                    end else begin
                        next_active[sel_grp] = 1'b0;
                    end
                end
            end
            ST_DISCH, ST_SAMPLE, ST_CONV: begin
                if (!active[cur_grp] || (preempt && !halt_meth[cur_grp])) begin
                    next_state = ST_IDLE;
                end else if (tick) begin
                    next_phase = phase + 4'h1;
                    if (state == ST_DISCH && phase == DISCH_TICKS - 4'h1) begin
                        next_state = ST_SAMPLE;
                        next_phase = 4'h0;
                    end else if (state == ST_SAMPLE && phase == SAMPLE_TICKS - 4'h1) begin
                        next_state = ST_CONV;
                        next_sar = 10'h200;
                        next_bit_idx = 4'd9;
                    end else if (state == ST_CONV) begin
                        trial = approximation_register;
                        if (!comp_s2) trial[bit_idx] = 1'b0;
                        if (bit_idx == 4'h0) begin
                            next_state = ST_STORE;
                        end else begin
                            trial[bit_idx - 4'h1] = 1'b1;
                            next_bit_idx = bit_idx - 4'h1;
                        end
                        next_sar = trial;
                    end
                end
            end
            ST_STORE: begin
                next_state = ST_IDLE;
                next_event = 1'b1;
                next_ch_res[cur_ch] = approximation_register;
                next_last_res = approximation_register;
                next_last_ch = cur_ch;
                next_grp_res[cur_grp] = approximation_register;
                if (unread[cur_ch]) next_ovw_st[cur_ch] = 1'b1;
                next_unread[cur_ch] = 1'b1;
                if (limit_en[cur_ch] && (approximation_register < lower || approximation_register > upper)) begin
                    next_range_st[cur_ch] = 1'b1;
                end
                if (ioc[cur_grp][cur_ch]) next_irq[cur_grp] = 1'b1;
                if (!(cur_grp == 2'd0 && mode0) && rep_cnt[cur_grp] != rep_cfg[cur_grp]) begin
                    next_rep_cnt[cur_grp] = rep_cnt[cur_grp] + 2'h1;
                    next_ch_pos[cur_grp] = cur_ch;
                end else begin
                    next_rep_cnt[cur_grp] = 2'h0;
                    hit = find_chan(scan[cur_grp], {1'b0, cur_ch} + 5'h01);
                    next_ch_pos[cur_grp] = hit[3:0];
                    grp_end = !hit[4];
                end
                if (grp_end) begin
                    if (ioc[cur_grp] == 16'h0000) next_irq[cur_grp] = 1'b1;
                    if (cur_grp == 2'd0 && mode0) begin
                        next_ch_pos[0] = 4'h0;
                    end else begin
                        next_active[cur_grp] = 1'b0;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase

        // disabling stops everything at once; a store already under way still writes its results but raises no event or interrupt
        if (!enable) begin
            next_active = 3'h0;
            next_state = ST_IDLE;
            next_event = 1'b0;
            next_irq = 3'h0;
        end

        next_afe.power     = power;
        next_afe.discharge = (next_state == ST_DISCH);
        next_afe.sample    = (next_state == ST_SAMPLE);
        next_afe.channel   = next_cur_ch;
        next_afe.dac       = next_sar;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable <= 1'b0; power <= 1'b0; mode0 <= 1'b0;
            trig_mode <= 1'b0; disch_en <= 1'b0; halt_meth <= 3'h0; freq <= 4'h0;
            limit_en <= 16'h0000; stab_val <= STAB_RESET;
            range_st <= 16'h0000; ovw_st <= 16'h0000; unread <= 16'h0000;
            lower <= 10'h000; upper <= UPPER_RESET; last_res <= 10'h000;
            approximation_register <= 10'h000; last_ch <= 4'h0; cur_ch <= 4'h0; phase <= 4'h0;
            bit_idx <= 4'h0; active <= 3'h0; cur_grp <= 2'h0; div_cnt <= 6'h00;
            stab_cnt <= 16'h0000; stab_done <= 1'b0; en_q <= 1'b0;
            state <= ST_IDLE; reg_rdata <= 32'h0000_0000; afe <= '0;
            per_conversion_event <= 1'b0; group_end_irq <= 3'h0;
            for (int g = 0; g < NUM_GRP; g++) begin
                rep_cfg[g] <= 2'h0; scan[g] <= 16'h0000; ioc[g] <= 16'h0000;
                grp_res[g] <= 10'h000; ch_pos[g] <= 4'h0; rep_cnt[g] <= 2'h0;
            end
            for (int m = 0; m < NUM_CH; m++) ch_res[m] <= 10'h000;
        end else begin
            enable <= next_enable; power <= next_power; mode0 <= next_mode0;
            trig_mode <= next_trig_mode; disch_en <= next_disch_en;
            halt_meth <= next_halt_meth; freq <= next_freq;
            limit_en <= next_limit_en; stab_val <= next_stab_val;
            range_st <= next_range_st; ovw_st <= next_ovw_st; unread <= next_unread;
            lower <= next_lower; upper <= next_upper; last_res <= next_last_res;
            approximation_register <= next_sar; last_ch <= next_last_ch; cur_ch <= next_cur_ch;
            phase <= next_phase; bit_idx <= next_bit_idx; active <= next_active;
            cur_grp <= next_cur_grp; div_cnt <= next_div_cnt;
            stab_cnt <= next_stab_cnt; stab_done <= next_stab_done;
            en_q <= enable && power; state <= next_state; reg_rdata <= next_rdata;
            afe <= next_afe; per_conversion_event <= next_event;
            group_end_irq <= next_irq;
            rep_cfg <= next_rep_cfg; scan <= next_scan; ioc <= next_ioc;
            grp_res <= next_grp_res; ch_pos <= next_ch_pos; rep_cnt <= next_rep_cnt;
            ch_res <= next_ch_res;
        end
    end

endmodule

// ### design/adc_seq_pkg.sv
/*
 * shared constants and types of the group scan sequencer: register offsets,
 * field positions, reset values, sequencing counts, state and carrier types.
 * assumes a single 125 MHz peripheral clock and a 32-bit plain register port.
 */
package adc_seq_pkg;

    localparam int NUM_CH   = 16;
    localparam int NUM_GRP  = 3;
    localparam int RES_BITS = 10;

    // register offsets (byte addresses)
    localparam logic [7:0] OFS_CTL0      = 8'h00;
    localparam logic [7:0] OFS_CTL1      = 8'h04;
    localparam logic [7:0] OFS_CTL2      = 8'h08;
    localparam logic [7:0] OFS_STAB      = 8'h0C;
    localparam logic [7:0] OFS_LOWER     = 8'h10;
    localparam logic [7:0] OFS_UPPER     = 8'h14;
    localparam logic [7:0] OFS_TRIG      = 8'h18;
    localparam logic [7:0] OFS_RANGE_ST  = 8'h1C;
    localparam logic [7:0] OFS_OVW_ST    = 8'h20;
    localparam logic [7:0] OFS_ACTIVE_ST = 8'h24;
    localparam logic [7:0] OFS_LAST_RES  = 8'h28;
    localparam logic [7:0] OFS_SCAN      = 8'h30;
    localparam logic [7:0] OFS_IOC       = 8'h40;
    localparam logic [7:0] OFS_GRP_RES   = 8'h50;
    localparam logic [7:0] OFS_CH_RES    = 8'h80;

    // control_reg_zero fields
    localparam int CTL0_ENABLE   = 0;
    localparam int CTL0_REPEAT   = 8;
    // control_reg_one fields
    localparam int CTL1_POWER    = 0;
    localparam int CTL1_MODE0    = 1;
    localparam int CTL1_TRIGMODE = 2;
    localparam int CTL1_DISCH    = 3;
    localparam int CTL1_HALT     = 4;
    localparam int CTL1_FREQ     = 8;
    // status fields: active status ready flag position, last result channel position
    localparam int ST_READY      = 8;
    localparam int LAST_CH_POS   = 16;

    localparam logic [15:0] STAB_RESET = 16'h0000;
    localparam logic [9:0]  UPPER_RESET = 10'h3FF;

    // sequencing counts in converter clock ticks
    localparam logic [3:0] DISCH_TICKS  = 4'h2;
    localparam logic [3:0] SAMPLE_TICKS = 4'h4;
    // system clocks per converter tick = (frequency_select_field + 1) * DIV_SCALE
    localparam logic [5:0] DIV_SCALE    = 6'h04;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_DISCH  = 3'b001,
        ST_SAMPLE = 3'b011,
        ST_CONV   = 3'b010,
        ST_STORE  = 3'b110
    } conv_state_t;

    typedef struct packed {
        logic       power;
        logic       discharge;
        logic       sample;
        logic [3:0] channel;
        logic [9:0] dac;
    } afe_ctrl_t;

endpackage

// ### tb/adc_seq_properties.sv
/* port assertions of the group scan sequencer.
   assumes one clock domain and a bind onto the design top at the foot. */
`timescale 1ns/1ps
module adc_seq_properties
    import adc_seq_pkg::*;
(
    input wire logic                   sys_clk,
    input wire logic                   arst_n,
    input wire logic                   reg_rd,
    input wire logic [31:0]            reg_rdata,
    input wire adc_seq_pkg::afe_ctrl_t afe,
    input wire logic                   per_conversion_event,
    input wire logic [2:0]             group_end_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////////////////////
    a_rdata_answer_only: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside answer cycle");
    a_event_spacing: assert property (per_conversion_event |=> !per_conversion_event[*8])
        else $error("conversion events too close");
    a_irq_pulse: assert property ((group_end_irq != 3'h0) |=> group_end_irq == 3'h0)
        else $error("end pulse longer than one cycle");
    a_irq_one_group: assert property ($onehot0(group_end_irq))
        else $error("two groups ended at once");
    a_sample_no_disch: assert property (afe.sample |-> !afe.discharge)
        else $error("discharge during sampling");
    a_sample_powered: assert property (afe.sample |-> afe.power)
        else $error("sampling while unpowered");
    a_disch_powered: assert property (afe.discharge |-> afe.power)
        else $error("discharge while unpowered");
    a_irq_powered: assert property ((group_end_irq != 3'h0) |-> afe.power)
        else $error("group end while unpowered");
endmodule
bind adc_group_scan_sequencer adc_seq_properties u_props (.sys_clk(sys_clk),
    .arst_n(arst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .afe(afe),
    .per_conversion_event(per_conversion_event), .group_end_irq(group_end_irq));

// ### tb/tb_adc_group_scan_sequencer.sv
/* self-checking bench of the group scan sequencer over the register port.
   assumes the checker is bound in by its own file; comparator modelled here. */
`timescale 1ns/1ps
module tb_adc_group_scan_sequencer;
    import adc_seq_pkg::*;
    logic        sys_clk, arst_n, reg_wr, reg_rd, per_conversion_event, halt_mode_trigger;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic [2:0]  hw_start_input, group_end_irq;
    logic [15:0] rng, ex;
    afe_ctrl_t   afe;
    logic [9:0]  vin [NUM_CH];
    logic [2:0]  seen [$];
    int          error_cnt, num_checks, cyc, ev_cnt, pop;
    adc_group_scan_sequencer u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .hw_start_input(hw_start_input), .halt_mode_trigger(halt_mode_trigger),
        .comp_in(vin[afe.channel] >= afe.dac), .afe(afe),
        .per_conversion_event(per_conversion_event), .group_end_irq(group_end_irq));
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge sys_clk);
    endtask
    task automatic cfg(input logic [31:0] c1, input logic [31:0] c0);
        wr(OFS_CTL0, 32'h0);
        wr(OFS_CTL1, c1);
        wr(OFS_CTL0, c0);
        v = 32'h0;
        for (int i = 0; i < 50 && !v[ST_READY]; i++) rd(OFS_ACTIVE_ST);
        chk("ready", 32'h1, v[ST_READY]);
    endtask
    task automatic run(input logic [31:0] t, input int n);
        seen.delete();
        ev_cnt = 0;
        wr(OFS_TRIG, t);
        for (int i = 0; i < 9000 && seen.size() < n; i++) @(posedge sys_clk);
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (per_conversion_event === 1'b1) ev_cnt++;
        if (group_end_irq !== 3'h0) seen.push_back(group_end_irq);
        if (cyc == 40000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata, hw_start_input, halt_mode_trigger} = '0;
        void'($urandom(41));
        foreach (vin[m]) vin[m] = 10'($urandom);
        rng = 16'($urandom) | 16'h8001;
        pop = $countones(rng);
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(OFS_UPPER);
        chk("upper reset", 32'(UPPER_RESET), v);
        rd(8'hFC);
        chk("unmapped", 32'h0, v);
        wr(OFS_STAB, 32'h2);
        wr(OFS_LOWER, 32'h100);
        wr(OFS_UPPER, 32'h300);
        wr(OFS_CTL2, 32'hFFFF);
        for (int hm = 0; hm < 2; hm++) begin
            cfg(32'h1 | (32'(hm) << 4), 32'h0101);
            wr(OFS_SCAN, {16'h0, rng});
            wr(OFS_SCAN + 8'h4, 32'h0);
            wr(OFS_SCAN + 8'h8, 32'h0010);
            run(32'h1, 0);
            rd(OFS_ACTIVE_ST);
            chk("active g0", 32'h1, v[2:0]);
            run(32'h6, 2);
            chk("first end", 32'h4, seen[0]);
            chk("second end", 32'h1, seen[1]);
            ex = '0;
            for (int m = 0; m < NUM_CH; m++) begin
                rd(OFS_CH_RES + 8'(4 * m));
                if (rng[m] || m == 4) begin
                    chk("channel result", 32'(vin[m]), v);
                    ex[m] = vin[m] < 10'h100 || vin[m] > 10'h300;
                end
            end
            chk("events", 32'(2 * pop + 1), ev_cnt);
            chk("ends", 32'h2, 32'(seen.size()));
        end
        rd(OFS_LAST_RES);
        chk("last channel", 32'hF, v[19:16]);
        chk("last value", 32'(vin[15]), v[9:0]);
        rd(OFS_GRP_RES);
        chk("group result", 32'(vin[15]), v);
        rd(OFS_RANGE_ST);
        chk("range", 32'(ex), v);
        rd(OFS_OVW_ST);
        chk("overwrite", 32'(rng), v);
        cfg(32'h5, 32'h0001);
        wr(OFS_SCAN + 8'h4, 32'h0200);
        halt_mode_trigger <= 1'b1;
        hw_start_input <= 3'b010;
        run(32'h0, 0);
        repeat (200) @(posedge sys_clk);
        chk("halt hold", 32'h0, ev_cnt);
        halt_mode_trigger <= 1'b0;
        run(32'h0, 1);
        hw_start_input <= 3'b000;
        chk("hw end", 32'h2, seen[0]);
        wr(OFS_CTL0, 32'h0);
        wr(OFS_IOC, 32'h1);
        cfg(32'hB, 32'h0001);
        wr(OFS_SCAN, 32'h0003);
        run(32'h1, 3);
        chk("rescan", 32'h1, seen[2]);
        chk("irq channel", 32'h5, ev_cnt);
        wr(OFS_CTL0, 32'h0);
        rd(OFS_ACTIVE_ST);
        chk("stopped", 32'h0, v[2:0]);
        close_out();
    end
endmodule
